// ===== wsmc_regs.vh
`ifndef WSMC_REGS_VH
`define WSMC_REGS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define WSMC_A_CTRL 8'h00
`define WSMC_A_MODES 8'h04
`define WSMC_A_CMD 8'h08
`define WSMC_A_SIZE 8'h0c
`define WSMC_A_REPEAT 8'h10
`define WSMC_A_DWELL 8'h14
`define WSMC_A_PDUR 8'h18
`define WSMC_A_SPHASE 8'h1c
`define WSMC_A_PPHASE 8'h20
`define WSMC_A_STATUS 8'h24
`define WSMC_A_REP 8'h28
`define WSMC_A_TEN0 8'h40
`define WSMC_A_TEN_LAST 8'h5c
// ----------------------------------------
// Field positions
// ----------------------------------------
`define WSMC_CTRL_OPM 1:0
`define WSMC_CTRL_AUTO 2
`define WSMC_CTRL_TSEL 3
`define WSMC_CTRL_SPM 6:4
`define WSMC_CMD_STEP 0
`define WSMC_CMD_PULSE 1
`define WSMC_CMD_LIST 2
`define WSMC_CMD_ARM 3
`define WSMC_CMD_ABORT 4
// ----------------------------------------
// Encodings and reset values
// ----------------------------------------
`define WSMC_OP_AC 2'h0
`define WSMC_OP_DC 2'h1
`define WSMC_OP_ACDC 2'h2
`define WSMC_M_IMM 2'h0
`define WSMC_M_STEP 2'h1
`define WSMC_M_PULSE 2'h2
`define WSMC_M_LIST 2'h3
`define WSMC_SRC_BASIC 2'h0
`define WSMC_SRC_SEG 2'h1
`define WSMC_SRC_LIST 2'h2
`define WSMC_SP_OFF 3'h0
`define WSMC_SP_STEP 3'h1
`define WSMC_SP_PULSE 3'h2
`define WSMC_SP_LIST 3'h3
`define WSMC_SP_ANY 3'h4
`define WSMC_ST_IDLE 2'h0
`define WSMC_ST_WAIT 2'h1
`define WSMC_ST_RUN 2'h2
`define WSMC_REP_FOREVER 32'hffffffff
`define WSMC_RST_DWELL 32'h00000001
`define WSMC_RST_PDUR 32'h00000001
`define WSMC_RST_REPEAT 32'h00000001
`define WSMC_RESP_OKAY 2'h0
`define WSMC_RESP_SLVERR 2'h2
`endif

// ===== wsmc_top.v
`include "wsmc_regs.vh"
module wsmc_top (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire trigger_source_select_in,
	input wire [11:0] list_start_phase,
	output wire [1:0] list_state,
	output wire [7:0] list_node,
	output wire [19:0] list_rep,
	output wire trigger_out_pulse,
	output wire [13:0] param_src,
	output wire phase_set,
	output wire [11:0] phase_value
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Byte-lane merge, shared by every writable register
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer b;
		begin
			for (b = 0; b < 4; b = b + 1) begin
				merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
			end
		end
	endfunction

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	reg aw_got_q, w_got_q, bvalid_q, rvalid_q;
	reg [7:0] awaddr_q;
	reg [31:0] wdata_q, rdata_q;
	reg [3:0] wstrb_q;
	reg [1:0] bresp_q, rresp_q;
	reg [31:0] ctrl_q, modes_q, size_q, repeat_q, dwell_q, pdur_q, sph_q, pph_q;
	reg [31:0] ten_q [0:7];
	reg [31:0] rd_d;
	reg rd_ok;
	wire wr_en = aw_got_q & w_got_q & ~bvalid_q;
	wire wr_ten = (awaddr_q >= `WSMC_A_TEN0) && (awaddr_q <= `WSMC_A_TEN_LAST);
	wire cmd_wr = wr_en && (awaddr_q == `WSMC_A_CMD) && wstrb_q[0];
	wire [4:0] cmd = cmd_wr ? wdata_q[4:0] : 5'h00;
	wire wr_known = wr_ten || (awaddr_q <= `WSMC_A_PPHASE);

	assign s_axi_awready = ~aw_got_q & ~bvalid_q;
	assign s_axi_wready = ~w_got_q & ~bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// Address and data are caught in either order; the write lands once both are held
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `WSMC_RESP_OKAY;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_en) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_known ? `WSMC_RESP_OKAY : `WSMC_RESP_SLVERR;
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Writable registers; the command word is never stored, it only pulses
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= 32'h00000000;
			modes_q <= 32'h00000000;
			size_q <= 32'h00000000;
			repeat_q <= `WSMC_RST_REPEAT;
			dwell_q <= `WSMC_RST_DWELL;
			pdur_q <= `WSMC_RST_PDUR;
			sph_q <= 32'h00000000;
			pph_q <= 32'h00000000;
		end else if (wr_en) begin
			case (awaddr_q)
				`WSMC_A_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000007f;
				`WSMC_A_MODES: modes_q <= merge(modes_q, wdata_q, wstrb_q) & 32'h00003fff;
				`WSMC_A_SIZE: size_q <= merge(size_q, wdata_q, wstrb_q) & 32'h000000ff;
				`WSMC_A_REPEAT: repeat_q <= merge(repeat_q, wdata_q, wstrb_q);
				`WSMC_A_DWELL: dwell_q <= merge(dwell_q, wdata_q, wstrb_q);
				`WSMC_A_PDUR: pdur_q <= merge(pdur_q, wdata_q, wstrb_q);
				`WSMC_A_SPHASE: sph_q <= merge(sph_q, wdata_q, wstrb_q) & 32'h00000fff;
				`WSMC_A_PPHASE: pph_q <= merge(pph_q, wdata_q, wstrb_q) & 32'h00000fff;
				default: ;
			endcase
		end
	end

	// Per-node trigger-out enables, one word per 32 nodes
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_ten
			always @(posedge aclk) begin
				if (!aresetn) begin
					ten_q[g] <= 32'h00000000;
				end else if (wr_en && wr_ten && (awaddr_q[4:2] == g)) begin
					ten_q[g] <= merge(ten_q[g], wdata_q, wstrb_q);
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Trigger pin and events
	// ----------------------------------------
	reg trg_m_q, trg_s_q, trg_d_q;
	reg step_done_q, step_ev_q, pulse_ev_q;
	reg [31:0] pcnt_q;
	wire pin_edge = trg_s_q & ~trg_d_q;
	wire step_trigger_source_select = pin_edge | cmd[`WSMC_CMD_STEP];
	wire pulse_trigger_source_select = pin_edge | cmd[`WSMC_CMD_PULSE];
	wire list_trigger_source_select = pin_edge | cmd[`WSMC_CMD_LIST];
	wire pulse_act = (pcnt_q != 32'h00000000);

	// Pin is asynchronous: two flops before the edge detector reads it
	always @(posedge aclk) begin
		if (!aresetn) begin
			trg_m_q <= 1'b0;
			trg_s_q <= 1'b0;
			trg_d_q <= 1'b0;
		end else begin
			trg_m_q <= trigger_source_select_in;
			trg_s_q <= trg_m_q;
			trg_d_q <= trg_s_q;
		end
	end

	// Step and pulse sequencers; arm and abort rewind the step, only abort rewinds the pulse
	always @(posedge aclk) begin
		if (!aresetn) begin
			step_done_q <= 1'b0;
			step_ev_q <= 1'b0;
			pulse_ev_q <= 1'b0;
			pcnt_q <= 32'h00000000;
		end else begin
			step_ev_q <= step_trigger_source_select;
			pulse_ev_q <= pulse_trigger_source_select;
			if (step_trigger_source_select)
				step_done_q <= 1'b1;
			else if (cmd[`WSMC_CMD_ARM] || cmd[`WSMC_CMD_ABORT])
				step_done_q <= 1'b0;
			if (pulse_trigger_source_select)
				pcnt_q <= (pdur_q == 32'h00000000) ? 32'h00000001 : pdur_q;
			else if (cmd[`WSMC_CMD_ABORT])
				pcnt_q <= 32'h00000000;
			else if (pulse_act)
				pcnt_q <= pcnt_q - 32'h00000001;
		end
	end

	// ----------------------------------------
	// List sequencer
	// ----------------------------------------
	localparam S_IDLE = `WSMC_ST_IDLE;
	localparam S_WAIT = `WSMC_ST_WAIT;
	localparam S_RUN = `WSMC_ST_RUN;
	reg [1:0] st_q;
	reg [7:0] node_q;
	reg [19:0] rep_q;
	reg [31:0] dcnt_q;
	reg hold_q, nstart_q;
	wire last_node = (node_q >= size_q[7:0]);
	wire last_rep = (repeat_q != `WSMC_REP_FOREVER) && (rep_q >= repeat_q[19:0]);
	wire node_done = (st_q == S_RUN) && ~hold_q && (dcnt_q == 32'h00000001);
	wire [31:0] dwell_ld = (dwell_q == 32'h00000000) ? 32'h00000001 : dwell_q;
	// auto advances alone, single-step waits for a trigger
	wire advance = (node_done && ~(last_node && last_rep) && ctrl_q[`WSMC_CTRL_AUTO])
		|| ((st_q == S_RUN) && hold_q && list_trigger_source_select);

	always @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= S_IDLE;
			node_q <= 8'h01;
			rep_q <= 20'h00001;
			dcnt_q <= 32'h00000000;
			hold_q <= 1'b0;
			nstart_q <= 1'b0;
		end else begin
			nstart_q <= 1'b0;
			case (st_q)
				S_IDLE: begin
					if (cmd[`WSMC_CMD_ARM] && (size_q[7:0] != 8'h00))
						st_q <= S_WAIT;
				end
				S_WAIT: begin
					if (cmd[`WSMC_CMD_ABORT]) begin
						st_q <= S_IDLE;
					end else if (list_trigger_source_select) begin
						st_q <= S_RUN;
						dcnt_q <= dwell_ld;
						hold_q <= 1'b0;
						nstart_q <= 1'b1;
					end
				end
				S_RUN: begin
					if (cmd[`WSMC_CMD_ABORT] || (node_done && last_node && last_rep)) begin
						// idle reports node and repetition one
						st_q <= S_IDLE;
						node_q <= 8'h01;
						rep_q <= 20'h00001;
						hold_q <= 1'b0;
					end else if (advance) begin
						// next node, wrapping into the next repetition
						node_q <= last_node ? 8'h01 : node_q + 8'h01;
						rep_q <= last_node ? rep_q + 20'h00001 : rep_q;
						dcnt_q <= dwell_ld;
						hold_q <= 1'b0;
						nstart_q <= 1'b1;
					end else if (node_done) begin
						hold_q <= 1'b1;
					end else if (~hold_q) begin
						dcnt_q <= dcnt_q - 32'h00000001;
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// state, node and repetition as held
	assign list_state = st_q;
	assign list_node = node_q;
	assign list_rep = rep_q;

	// ----------------------------------------
	// Trigger out
	// ----------------------------------------
	reg tout_q;
	wire [7:0] nidx = node_q - 8'h01;
	wire [31:0] ten_w = ten_q[nidx[7:5]];
	// enable bit of the node just started, gated by source select
	always @(posedge aclk) begin
		if (!aresetn)
			tout_q <= 1'b0;
		else
			tout_q <= nstart_q & ten_w[nidx[4:0]] & ctrl_q[`WSMC_CTRL_TSEL];
	end
	assign trigger_out_pulse = tout_q;

	// ----------------------------------------
	// Parameter source selection
	// ----------------------------------------
	wire [1:0] opm = ctrl_q[`WSMC_CTRL_OPM];
	wire op_acdc = (opm == `WSMC_OP_ACDC);
	wire op_acv = (opm == `WSMC_OP_AC) || op_acdc;
	wire [13:0] src_d;
	reg [13:0] src_q;
	// seven selectors; AC amplitude in AC or AC-DC
	generate
		for (g = 0; g < 7; g = g + 1) begin : g_src
			wire [1:0] m = modes_q[2*g +: 2];
			// DC offset and DC slew only in AC-DC
			wire en = ((g == 1) || (g == 5)) ? op_acdc : ((g == 0) ? op_acv : 1'b1);
			assign src_d[2*g +: 2] = (!en || m == `WSMC_M_IMM) ? `WSMC_SRC_BASIC :
				(m == `WSMC_M_STEP) ? (step_done_q ? `WSMC_SRC_SEG : `WSMC_SRC_BASIC) :
				(m == `WSMC_M_PULSE) ? (pulse_act ? `WSMC_SRC_SEG : `WSMC_SRC_BASIC) :
				`WSMC_SRC_LIST;
		end
	endgenerate

	always @(posedge aclk) begin
		if (!aresetn)
			src_q <= 14'h0000;
		else
			src_q <= src_d;
	end
	assign param_src = src_q;

	// ----------------------------------------
	// Start phase
	// ----------------------------------------
	// Events are all registered one cycle so a shared trigger lands together
	reg ph_set_q;
	reg [11:0] ph_val_q;
	always @(posedge aclk) begin
		if (!aresetn) begin
			ph_set_q <= 1'b0;
			ph_val_q <= 12'h000;
		end else begin
			ph_set_q <= 1'b0;
			case (ctrl_q[`WSMC_CTRL_SPM])
				`WSMC_SP_OFF: ph_set_q <= 1'b0;
				`WSMC_SP_STEP: begin
					ph_set_q <= step_ev_q;
					if (step_ev_q) ph_val_q <= sph_q[11:0];
				end
				`WSMC_SP_PULSE: begin
					ph_set_q <= pulse_ev_q;
					if (pulse_ev_q) ph_val_q <= pph_q[11:0];
				end
				`WSMC_SP_LIST: begin
					ph_set_q <= nstart_q;
					if (nstart_q) ph_val_q <= list_start_phase;
				end
				`WSMC_SP_ANY: begin
					ph_set_q <= step_ev_q | pulse_ev_q | nstart_q;
					if (step_ev_q) ph_val_q <= sph_q[11:0];
					else if (pulse_ev_q) ph_val_q <= pph_q[11:0];
					else if (nstart_q) ph_val_q <= list_start_phase;
				end
				default: ph_set_q <= 1'b0;
			endcase
		end
	end
	assign phase_set = ph_set_q;
	assign phase_value = ph_val_q;

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always @* begin
		rd_ok = 1'b1;
		rd_d = 32'h00000000;
		case ({s_axi_araddr[7:2], 2'b00})
			`WSMC_A_CTRL: rd_d = ctrl_q;
			`WSMC_A_MODES: rd_d = modes_q;
			`WSMC_A_CMD: rd_d = 32'h00000000;
			`WSMC_A_SIZE: rd_d = size_q;
			`WSMC_A_REPEAT: rd_d = repeat_q;
			`WSMC_A_DWELL: rd_d = dwell_q;
			`WSMC_A_PDUR: rd_d = pdur_q;
			`WSMC_A_SPHASE: rd_d = sph_q;
			`WSMC_A_PPHASE: rd_d = pph_q;
			`WSMC_A_STATUS: rd_d = {16'h0000, node_q, 4'h0, pulse_act, step_done_q, st_q};
			`WSMC_A_REP: rd_d = {12'h000, rep_q};
			default: begin
				if (s_axi_araddr >= `WSMC_A_TEN0 && s_axi_araddr <= `WSMC_A_TEN_LAST + 8'h03)
					rd_d = ten_q[s_axi_araddr[4:2]];
				else
					rd_ok = 1'b0;
			end
		endcase
	end

	// Unmapped reads answer zero with a slave error
	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `WSMC_RESP_OKAY;
		end else if (s_axi_arvalid && ~rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_d;
			rresp_q <= rd_ok ? `WSMC_RESP_OKAY : `WSMC_RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
endmodule

// ===== wsmc_list_store.sv
module wsmc_list_store (
	input wire [7:0] list_node,
	output logic [11:0] list_start_phase
);
	timeunit 1ns;
	timeprecision 1ps;
	// Phase tracks the node index, so a lookup for the wrong node is visible
	assign list_start_phase = 12'h300 + {4'h0, list_node};
endmodule

// ===== wsmc_checker.sv
module wsmc_checker (
	input wire aclk,
	input wire aresetn,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] list_state,
	input wire [7:0] list_node,
	input wire [19:0] list_rep,
	input wire trigger_out_pulse,
	input wire [13:0] param_src,
	input wire phase_set,
	input wire [11:0] phase_value
);
	timeunit 1ns;
	timeprecision 1ps;
	// One clock domain, so one default clock and reset for all properties
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_state_code: assert property (list_state != 2'h3)
		else $error("list state shows an unused code");
	a_idle_ones: assert property (
		list_state != 2'h2 |-> list_node == 8'h01 && list_rep == 20'h00001)
		else $error("node or repetition not one outside run");
	a_out_in_run: assert property (trigger_out_pulse |-> $past(list_state) == 2'h2)
		else $error("trigger out without a running list");
	a_run_first: assert property (
		$past(list_state) == 2'h1 && list_state == 2'h2 |-> list_node == 8'h01)
		else $error("run did not begin on the first node");
	a_no_jump: assert property ($past(list_state) == 2'h0 |-> list_state != 2'h2)
		else $error("idle went straight to run");
	a_phase_cause: assert property ($changed(phase_value) |-> phase_set)
		else $error("phase value moved without phase set");
	a_src_code: assert property ((param_src & (param_src >> 1) & 14'h1555) == 14'h0)
		else $error("parameter source holds an unused code");
	// The bench delays bready, so a response must stand unchanged meanwhile
	a_resp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
endmodule

bind wsmc_top wsmc_checker u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .list_state(list_state),
	.list_node(list_node), .list_rep(list_rep), .trigger_out_pulse(trigger_out_pulse),
	.param_src(param_src), .phase_set(phase_set), .phase_value(phase_value));

// ===== tb_waveform_sequencer_mode_control.sv
`include "wsmc_regs.vh"
module tb_waveform_sequencer_mode_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, awv, wv, bry, arv, rry, trigger_source_select, ts;
	logic [7:0] awa, ara;
	logic [31:0] wd, d, en;
	logic [1:0] r;
	logic [19:0] mrep;
	wire awr, wrd, bv, arr, rv, tp, ps;
	wire [1:0] br, rr, st;
	wire [31:0] rdt;
	wire [11:0] sph, pv;
	wire [7:0] nd;
	wire [19:0] rep;
	wire [13:0] src;
	int errors, num_checks, cyc, n_tp, n_ps, seed, sz, dw, rp;
	wsmc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .trigger_source_select_in(trigger_source_select),
		.list_start_phase(sph), .list_state(st), .list_node(nd), .list_rep(rep),
		.trigger_out_pulse(tp), .param_src(src), .phase_set(ps), .phase_value(pv));
	wsmc_list_store u_store (.list_node(nd), .list_start_phase(sph));
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// Count one-cycle events and cut a hang short
	always @(posedge aclk) begin
		cyc++;
		if (tp === 1'b1) n_tp++;
		if (ps === 1'b1) n_ps++;
		if (rep > mrep) mrep = rep;
		if (cyc == 30000) begin
			errors++;
			final_report();
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
		chk(nm, 32'(e), 32'(g));
	endtask
	// Ready is raised a cycle late so the slave has to hold its answer
	// No cycle limit here: only the bench watchdog may end a wait for an answer
	task automatic ans(input bit wside, output logic [1:0] rs);
		do begin
			@(negedge aclk);
		end while ((wside ? bv : rv) !== 1'b1);
		@(posedge aclk);
		if (wside) bry <= 1'b1;
		else rry <= 1'b1;
		@(negedge aclk);
		rs = wside ? br : rr;
		d = rdt;
		@(posedge aclk);
		bry <= 1'b0;
		rry <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		bit pa, pw, ha, hw;
		pa = 1;
		pw = 1;
		@(posedge aclk);
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		while (pa || pw) begin
			@(negedge aclk);
			ha = pa && awr;
			hw = pw && wrd;
			@(posedge aclk);
			if (ha) awv <= 1'b0;
			if (hw) wv <= 1'b0;
			pa = pa && !ha;
			pw = pw && !hw;
		end
		ans(1'b1, rs);
	endtask
	task automatic rd(input logic [7:0] a, output logic [1:0] rs);
		bit h;
		h = 0;
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		while (!h) begin
			@(negedge aclk);
			h = arr;
			@(posedge aclk);
		end
		arv <= 1'b0;
		ans(1'b0, rs);
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] v);
		wr(a, v, r);
		chk_resp("write resp", `WSMC_RESP_OKAY, r);
	endtask
	task automatic cw(input int k);
		repeat (k) @(negedge aclk);
	endtask
	task automatic wait_st(input logic [1:0] s);
		int n;
		n = 0;
		while (st !== s && n < 3000) begin
			@(negedge aclk);
			n++;
		end
		chk("list state", 32'(s), 32'(st));
	endtask
	function automatic logic [31:0] exp_tp(logic [31:0] e, int s, int n, logic t);
		int c;
		c = 0;
		for (int j = 0; j < s; j++) c += e[j];
		return t ? 32'(c * n) : 32'h0;
	endfunction
	function automatic logic [31:0] exp_ph(int k);
		return (k == 1 || k == 4) ? 32'h111 : (k == 3) ? 32'h301 : 32'h222;
	endfunction
	// All seven selectors in step mode; disabled ones fall back to basic
	function automatic logic [31:0] exp_src(int op);
		logic [31:0] v;
		v = 32'h1555;
		if (op != 2) v &= ~32'h404;
		if (op == 1) v &= ~32'h1;
		return v;
	endfunction
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		seed = 47184;
		{awv, wv, bry, arv, rry, trigger_source_select, aresetn} = 7'h0;
		{awa, ara, wd, mrep} = 68'h0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`WSMC_A_REPEAT, r);
		chk("repeat reset", `WSMC_RST_REPEAT, d);
		rd(8'h30, r);
		chk_resp("unmapped read", `WSMC_RESP_SLVERR, r);
		wr(8'h30, 32'h5, r);
		chk_resp("unmapped write", `WSMC_RESP_SLVERR, r);
		$display("test reset done");
		// Amplitude apply_at_once, shape step, frequency pulse of 20 cycles
		w(`WSMC_A_PDUR, 32'd20);
		w(`WSMC_A_MODES, 32'h90);
		cw(2);
		chk("source idle", 32'h0, 32'(src));
		w(`WSMC_A_CMD, 32'h3);
		cw(3);
		chk("source in pulse", 32'h50, 32'(src));
		cw(30);
		chk("source after pulse", 32'h10, 32'(src));
		w(`WSMC_A_CMD, 32'h10);
		w(`WSMC_A_MODES, 32'h1555);
		w(`WSMC_A_CMD, 32'h1);
		for (int k = 0; k < 3; k++) begin
			w(`WSMC_A_CTRL, 32'(k));
			cw(3);
			chk("source per op", exp_src(k), 32'(src));
		end
		w(`WSMC_A_CMD, 32'h10);
		$display("test source modes done");
		// Random list shapes; trigger by command, then by the pin
		for (int i = 0; i < 4; i++) begin
			sz = 2 + $unsigned($random(seed)) % 3;
			dw = 4 + $unsigned($random(seed)) % 4;
			rp = 1 + $unsigned($random(seed)) % 2;
			en = $random(seed);
			ts = i[0];
			w(`WSMC_A_CTRL, 32'h4 | (32'(ts) << 3));
			w(`WSMC_A_SIZE, 32'(sz));
			w(`WSMC_A_REPEAT, 32'(rp));
			w(`WSMC_A_DWELL, 32'(dw));
			w(`WSMC_A_TEN0, en);
			w(`WSMC_A_MODES, 32'h3);
			w(`WSMC_A_CMD, 32'h8);
			cw(1);
			chk("armed", 32'h10101, {14'h0, st, nd, rep[7:0]});
			n_tp = 0;
			mrep = 20'h0;
			if (i < 2) w(`WSMC_A_CMD, 32'h4);
			else begin
				@(posedge aclk);
				trigger_source_select <= 1'b1;
				repeat (4) @(posedge aclk);
				trigger_source_select <= 1'b0;
			end
			wait_st(`WSMC_ST_RUN);
			cw(2);
			chk("list source", 32'h2, 32'(src[1:0]));
			wait_st(`WSMC_ST_IDLE);
			chk("trigger outs", exp_tp(en, sz, rp, ts), 32'(n_tp));
			chk("last repetition", 32'(rp), 32'(mrep));
		end
		$display("test list runs done");
		// Single step: second trigger is needed for node two
		w(`WSMC_A_CTRL, 32'h8);
		w(`WSMC_A_SIZE, 32'h2);
		w(`WSMC_A_REPEAT, 32'h1);
		w(`WSMC_A_TEN0, 32'h3);
		w(`WSMC_A_CMD, 32'h8);
		n_tp = 0;
		w(`WSMC_A_CMD, 32'h4);
		cw(40);
		chk("held on node one", 32'h201, {22'h0, st, nd});
		w(`WSMC_A_CMD, 32'h4);
		wait_st(`WSMC_ST_IDLE);
		chk("step pulses", 32'h2, 32'(n_tp));
		// Endless repeat keeps running until aborted
		w(`WSMC_A_CTRL, 32'h4);
		w(`WSMC_A_SIZE, 32'h1);
		w(`WSMC_A_DWELL, 32'h1);
		w(`WSMC_A_REPEAT, `WSMC_REP_FOREVER);
		w(`WSMC_A_CMD, 32'h8);
		w(`WSMC_A_CMD, 32'h4);
		cw(60);
		chk("endless run", 32'h3, {30'h0, st == `WSMC_ST_RUN, rep > 20'd10});
		w(`WSMC_A_CMD, 32'h10);
		wait_st(`WSMC_ST_IDLE);
		$display("test step and endless done");
		// Start phase modes off, step, pulse, list, any, any without step
		w(`WSMC_A_SPHASE, 32'h111);
		w(`WSMC_A_PPHASE, 32'h222);
		w(`WSMC_A_REPEAT, 32'h1);
		w(`WSMC_A_DWELL, 32'h2);
		for (int k = 0; k < 6; k++) begin
			w(`WSMC_A_CMD, 32'h10);
			w(`WSMC_A_CTRL, 32'h4 | (32'(k > 4 ? 4 : k) << 4));
			w(`WSMC_A_CMD, 32'h8);
			n_ps = 0;
			w(`WSMC_A_CMD, k == 5 ? 32'h6 : 32'h7);
			wait_st(`WSMC_ST_IDLE);
			cw(3);
			chk("phase sets", 32'(k != 0), 32'(n_ps));
			if (k != 0) chk("phase value", exp_ph(k), 32'(pv));
		end
		$display("test start phase done");
		final_report();
	end
endmodule
